// File: verilog/mi_pkg.sv
// Shared constants and types for the moving inversions checker
package mi_pkg;

	// Memory word, control memory address and error code widths
	localparam int unsigned WORD_W = 16;
	localparam int unsigned ADDR_W = 22;
	localparam int unsigned CODE_W = 4;

	// Test patterns and address constants
	localparam logic [WORD_W-1:0] PAT_ZERO = 16'h0000;
	localparam logic [WORD_W-1:0] PAT_ONES = 16'hffff;
	localparam logic [WORD_W-1:0] PAT_LSB  = 16'h0001;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 22'h000001;
	localparam logic [ADDR_W-1:0] ADDR_NONE = 22'h000000;

	// Error codes; the step codes are {descending, zero adding, reread}
	localparam logic [CODE_W-1:0] ERR_INIT_TIMEOUT = 4'h8;
	localparam logic [CODE_W-1:0] ERR_DIAG_TIMEOUT = 4'h9;
	localparam logic [CODE_W-1:0] ERR_MEM_PARITY   = 4'ha;
	localparam logic [CODE_W-1:0] ERR_NONEXISTENT  = 4'hb;
	localparam logic [CODE_W-1:0] ERR_NO_AREA      = 4'hc;
	localparam logic [CODE_W-1:0] ERR_CACHE_PARITY = 4'hd;
	localparam logic [CODE_W-1:0] ERR_STEP_LAST    = 4'h7;

	// Requestor timeout: time in milliseconds and clock rate in hertz
	localparam longint unsigned TIMEOUT_MS  = 4200;
	localparam longint unsigned CLOCK_HZ    = 10_000_000;
	localparam longint unsigned MS_PER_SEC  = 1000;
	localparam int unsigned TIMEOUT_CYC_DEFAULT =
		int'(TIMEOUT_MS * CLOCK_HZ / MS_PER_SEC);

	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_CLEAR     = 4'h1,
		ST_READ      = 4'h2,
		ST_WRITE     = 4'h3,
		ST_VERIFY    = 4'h4,
		ST_INIT_WAIT = 4'h5,
		ST_DIAG_WAIT = 4'h6,
		ST_DONE      = 4'h7
	} state_t;

	typedef struct packed {
		logic [CODE_W-1:0] code;
		logic [ADDR_W-1:0] failing_address;
		logic [WORD_W-1:0] expected_pattern;
		logic [WORD_W-1:0] actual_pattern;
		logic              has_data;
		logic              dual_address;
	} err_record_t;

endpackage

// File: verilog/mi_timeout.sv
// Cycle counter that flags a requestor timeout
`timescale 1ns/1ps
module mi_timeout #(
	parameter int unsigned LIMIT = 16
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic run,
	output logic      expired
);
	logic [31:0] count;

	// Counts while running, clears when idle, saturates at LIMIT - 1
	always_ff @(posedge clk) begin
		if (rst || !run) begin
			count <= 32'h0;
		end else if (count != LIMIT - 1) begin
			count <= count + 32'h1;
		end
	end

	assign expired = run && (count == LIMIT - 1);
endmodule // mi_timeout

// File: verilog/mi_classifier.sv
// Dual addressing signature check for one data mismatch
`timescale 1ns/1ps
module mi_classifier
	import mi_pkg::*;
(
	input  wire logic              zero_add,
	input  wire logic [WORD_W-1:0] expected,
	input  wire logic [WORD_W-1:0] actual,
	output logic                   dual
);
	logic [WORD_W-1:0] one_sig;
	logic [WORD_W-1:0] zero_sig;

	// Next pattern of the running step is the fault signature
	assign one_sig  = {expected[WORD_W-2:0], 1'b1};
	assign zero_sig = {1'b0, expected[WORD_W-1:1]};

	always_comb begin
		if (zero_add) begin
			dual = (expected != PAT_ZERO) && (actual == zero_sig);
		end else begin
			dual = (expected != PAT_ONES) && (actual == one_sig);
		end
	end
endmodule // mi_classifier

// File: verilog/moving_inversions_error_report.sv
// Moving inversions control memory test with error classification
//
// Summary of operation
// - Codes 0 to 7 mark control memory mismatches, one per test step
// - Only the requestor control area range is addressed, never data memory
// - Requestor init not done before timeout reports code 8
// - Requestor microdiagnostic not done before timeout reports code 9
// - Memory parity trap reports code 10, nonexistent memory trap code 11
// - Trap and timeout reports carry no expected or actual word
// - No working control area available reports code 12
// - Cache parity trap reports code 13, apart from memory parity
// - Mismatch reports carry failing address, expected and actual words
// - Ascending one adding read-before-rewrite mismatch reports code 0
// - One adding dual addressing: actual is expected plus next left 1
// - Code 0 dual signature means a lower address write hit it
// - Immediate reread failures report codes 1, 3, 5 or 7 by step
// - Ascending zero adding read-before-rewrite mismatch reports code 2
// - Zero adding dual addressing: extra 0 at expected leftmost 1
// - Descending one adding read mismatch reports code 4
// - Words differing in more than one bit are plain data errors
// - One adding: fewer ones than expected is a plain data error
// - Zero adding: more ones than expected is a plain data error
// - Zero adding: single bit off the leftmost position is data error
// - Each run first clears every tested word to zero
// - Ones are added until all ones, then removed until all zero
// - After ascending passes the sequence repeats highest to lowest
`timescale 1ns/1ps
module moving_inversions_error_report
	import mi_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC_DEFAULT
) (
	input  wire logic              CLOCK,
	input  wire logic              SYS_RST,
	input  wire logic              START,
	input  wire logic              AREA_FOUND,
	input  wire logic [ADDR_W-1:0] AREA_FIRST,
	input  wire logic [ADDR_W-1:0] AREA_LAST,
	output logic                   MEM_REQ,
	output logic                   MEM_WRITE,
	output logic      [ADDR_W-1:0] MEM_ADDR,
	output logic      [WORD_W-1:0] MEM_WDATA,
	input  wire logic              MEM_ACK,
	input  wire logic [WORD_W-1:0] MEM_RDATA,
	input  wire logic              MEM_PARITY_TRAP,
	input  wire logic              NONEXISTENT_MEMORY_TRAP,
	input  wire logic              CACHE_PARITY_TRAP,
	output logic                   REQ_ENABLE,
	output logic                   REQ_TEST_GO,
	input  wire logic              REQ_INIT_DONE,
	input  wire logic              REQ_DIAG_DONE,
	output logic                   BUSY,
	output logic                   TEST_DONE,
	output logic                   ERR_VALID,
	output err_record_t            ERR_RECORD
);
	import mi_pkg::*;

	state_t            state;
	state_t            next_state;
	logic [ADDR_W-1:0] area_lo;
	logic [ADDR_W-1:0] area_hi;
	logic [WORD_W-1:0] pat;
	logic [WORD_W-1:0] wpat;
	logic              down;
	logic              zero_add;
	logic              mem_phase;
	logic              mem_trap;
	logic              pass_end;
	logic              init_expired;
	logic              diag_expired;
	logic              dual;
	logic              mismatch;
	logic [ADDR_W-1:0] first_addr;
	logic [ADDR_W-1:0] last_addr;
	logic [ADDR_W-1:0] step_addr;
	logic              next_valid;
	err_record_t       next_rec;

	assign mem_phase = (state == ST_CLEAR) || (state == ST_READ)
		|| (state == ST_WRITE) || (state == ST_VERIFY);
	assign mem_trap = mem_phase
		&& (MEM_PARITY_TRAP || NONEXISTENT_MEMORY_TRAP);
	assign first_addr = down ? area_hi : area_lo;
	assign last_addr  = down ? area_lo : area_hi;
	assign pass_end   = (MEM_ADDR == last_addr);
	assign step_addr  = down ? MEM_ADDR - ADDR_STEP : MEM_ADDR + ADDR_STEP;

	// Memory bus handshake, busy and done status
	assign MEM_REQ   = mem_phase;
	assign MEM_WRITE = (state == ST_CLEAR) || (state == ST_WRITE);
	assign BUSY      = (state != ST_IDLE);
	assign TEST_DONE = (state == ST_DONE);

	mi_timeout #(
		.LIMIT(TIMEOUT_CYCLES)
	) u_init_tmo (
		.clk    (CLOCK),
		.rst    (SYS_RST),
		.run    (state == ST_INIT_WAIT),
		.expired(init_expired)
	);

	mi_timeout #(
		.LIMIT(TIMEOUT_CYCLES)
	) u_diag_tmo (
		.clk    (CLOCK),
		.rst    (SYS_RST),
		.run    (state == ST_DIAG_WAIT),
		.expired(diag_expired)
	);

	mi_classifier u_class (
		.zero_add(zero_add),
		.expected(pat),
		.actual  (MEM_RDATA),
		.dual    (dual)
	);

	// Sequencer
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (START && AREA_FOUND) begin
					next_state = ST_CLEAR;
				end
			end
			ST_CLEAR: begin
				if (MEM_ACK && pass_end) begin
					next_state = ST_READ;
				end
			end
			ST_READ: begin
				if (MEM_ACK) begin
					next_state = ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (MEM_ACK) begin
					next_state = ST_VERIFY;
				end
			end
			ST_VERIFY: begin
				if (MEM_ACK && pass_end && zero_add && wpat == PAT_ZERO) begin
					next_state = down ? ST_INIT_WAIT : ST_CLEAR;
				end else if (MEM_ACK) begin
					next_state = ST_READ;
				end
			end
			ST_INIT_WAIT: begin
				if (REQ_INIT_DONE) begin
					next_state = ST_DIAG_WAIT;
				end else if (init_expired) begin
					next_state = ST_DONE;
				end
			end
			ST_DIAG_WAIT: begin
				if (REQ_DIAG_DONE || diag_expired) begin
					next_state = ST_DONE;
				end
			end
			ST_DONE: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (mem_trap) begin
			next_state = ST_CLEAR;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Area bounds captured at start; only these words are touched
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			area_lo <= ADDR_NONE;
			area_hi <= ADDR_NONE;
		end else if (state == ST_IDLE && START) begin
			area_lo <= AREA_FIRST;
			area_hi <= AREA_LAST;
		end
	end

	// Address, direction and pattern walk
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			MEM_ADDR <= ADDR_NONE;
			down     <= 1'b0;
			zero_add <= 1'b0;
			pat      <= PAT_ZERO;
			wpat     <= PAT_ZERO;
		end else if (mem_trap || (state == ST_IDLE && START)) begin
			MEM_ADDR <= (state == ST_IDLE) ? AREA_FIRST : area_lo;
			down     <= 1'b0;
			zero_add <= 1'b0;
			pat      <= PAT_ZERO;
			wpat     <= PAT_ZERO;
		end else if (state == ST_CLEAR && MEM_ACK) begin
			MEM_ADDR <= pass_end ? first_addr : step_addr;
			if (pass_end) begin
				wpat <= PAT_LSB;
			end
		end else if (state == ST_VERIFY && MEM_ACK) begin
			MEM_ADDR <= pass_end ? first_addr : step_addr;
			if (pass_end) begin
				pat <= wpat;
				if (zero_add && wpat == PAT_ZERO) begin
					down     <= 1'b1;
					zero_add <= 1'b0;
					MEM_ADDR <= area_hi;
				end else if (!zero_add && wpat == PAT_ONES) begin
					zero_add <= 1'b1;
					wpat     <= {1'b0, wpat[WORD_W-1:1]};
				end else if (zero_add) begin
					wpat <= {1'b0, wpat[WORD_W-1:1]};
				end else begin
					wpat <= {wpat[WORD_W-2:0], 1'b1};
				end
			end
		end
	end

	assign MEM_WDATA = wpat;

	// Requestor control
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			REQ_ENABLE  <= 1'b0;
			REQ_TEST_GO <= 1'b0;
		end else begin
			REQ_ENABLE  <= (next_state == ST_INIT_WAIT)
				|| (next_state == ST_DIAG_WAIT);
			REQ_TEST_GO <= (state == ST_INIT_WAIT)
				&& (next_state == ST_DIAG_WAIT);
		end
	end

	// Error record selection
	assign mismatch = MEM_ACK && (MEM_RDATA != (state == ST_READ ? pat : wpat));

	always_comb begin
		next_valid = 1'b0;
		next_rec   = '0;
		if (state == ST_IDLE && START && !AREA_FOUND) begin
			next_valid    = 1'b1;
			next_rec.code = ERR_NO_AREA;
		end else if (mem_trap) begin
			next_valid = 1'b1;
			next_rec.code = MEM_PARITY_TRAP ? ERR_MEM_PARITY
				: ERR_NONEXISTENT;
			next_rec.failing_address = MEM_ADDR;
		end else if (BUSY && CACHE_PARITY_TRAP) begin
			next_valid    = 1'b1;
			next_rec.code = ERR_CACHE_PARITY;
		end else if (state == ST_INIT_WAIT && !REQ_INIT_DONE
			&& init_expired) begin
			next_valid    = 1'b1;
			next_rec.code = ERR_INIT_TIMEOUT;
		end else if (state == ST_DIAG_WAIT && !REQ_DIAG_DONE
			&& diag_expired) begin
			next_valid    = 1'b1;
			next_rec.code = ERR_DIAG_TIMEOUT;
		end else if ((state == ST_READ || state == ST_VERIFY) && mismatch) begin
			next_valid = 1'b1;
			next_rec.code = {1'b0, down, zero_add,
				state == ST_VERIFY};
			next_rec.failing_address  = MEM_ADDR;
			next_rec.expected_pattern = (state == ST_READ) ? pat : wpat;
			next_rec.actual_pattern   = MEM_RDATA;
			next_rec.has_data         = 1'b1;
			next_rec.dual_address     = (state == ST_READ) && dual;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			ERR_VALID  <= 1'b0;
			ERR_RECORD <= '0;
		end else begin
			ERR_VALID <= next_valid;
			if (next_valid) begin
				ERR_RECORD <= next_rec;
			end
		end
	end

	// Checks
	sequence s_read_miss;
		state == ST_READ && MEM_ACK && MEM_RDATA != pat && !mem_trap
			&& !CACHE_PARITY_TRAP;
	endsequence

	sequence s_verify_miss;
		state == ST_VERIFY && MEM_ACK && MEM_RDATA != wpat && !mem_trap
			&& !CACHE_PARITY_TRAP;
	endsequence

	a_read_step_code: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		s_read_miss |=> ERR_VALID && ERR_RECORD.code == {1'b0,
		$past(down), $past(zero_add), 1'b0}
		&& ERR_RECORD.actual_pattern == $past(MEM_RDATA))
		else $error("read check mismatch code wrong");

	a_reread_code: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		s_verify_miss |=> ERR_VALID && ERR_RECORD.code[0]
		&& !ERR_RECORD.dual_address
		&& ERR_RECORD.expected_pattern == $past(wpat))
		else $error("reread mismatch code wrong");

	a_mismatch_addr: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(s_read_miss or s_verify_miss) |=> ERR_RECORD.has_data
		&& ERR_RECORD.failing_address == $past(MEM_ADDR))
		else $error("mismatch record lacks address");

	a_trap_no_data: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		ERR_VALID && ERR_RECORD.code > ERR_STEP_LAST |-> !ERR_RECORD.has_data
		&& ERR_RECORD.expected_pattern == PAT_ZERO
		&& ERR_RECORD.actual_pattern == PAT_ZERO)
		else $error("trap report carries data");

	a_mem_trap_code: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		mem_trap |=> ERR_VALID && ERR_RECORD.code ==
		($past(MEM_PARITY_TRAP) ? ERR_MEM_PARITY : ERR_NONEXISTENT)
		&& state == ST_CLEAR)
		else $error("memory trap not reported");

	a_cache_trap_code: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		BUSY && CACHE_PARITY_TRAP && !mem_trap |=> ERR_VALID
		&& ERR_RECORD.code == ERR_CACHE_PARITY)
		else $error("cache trap not reported");

	a_no_area_code: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		state == ST_IDLE && START && !AREA_FOUND |=> ERR_VALID
		&& ERR_RECORD.code == ERR_NO_AREA && state == ST_IDLE)
		else $error("missing area not reported");

	a_init_timeout: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		state == ST_INIT_WAIT && init_expired && !REQ_INIT_DONE
		&& !CACHE_PARITY_TRAP |=> ERR_VALID
		&& ERR_RECORD.code == ERR_INIT_TIMEOUT ##1 state == ST_IDLE)
		else $error("init timeout not reported");

	a_diag_timeout: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		state == ST_DIAG_WAIT && diag_expired && !REQ_DIAG_DONE
		&& !CACHE_PARITY_TRAP |=> ERR_VALID
		&& ERR_RECORD.code == ERR_DIAG_TIMEOUT)
		else $error("diagnostic timeout not reported");

	a_dual_one_add: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		s_read_miss ##0 !zero_add |=> ERR_RECORD.dual_address ==
		(ERR_RECORD.actual_pattern == {ERR_RECORD.expected_pattern[14:0],
		1'b1} && ERR_RECORD.expected_pattern != PAT_ONES))
		else $error("one adding dual class wrong");

	a_dual_zero_add: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		s_read_miss ##0 zero_add |=> ERR_RECORD.dual_address ==
		(ERR_RECORD.actual_pattern == {1'b0,
		ERR_RECORD.expected_pattern[15:1]}
		&& ERR_RECORD.expected_pattern != PAT_ZERO))
		else $error("zero adding dual class wrong");

	a_area_bounds: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		MEM_REQ |-> MEM_ADDR >= area_lo && MEM_ADDR <= area_hi)
		else $error("access outside control area");

	a_clear_first: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		state == ST_IDLE && START && AREA_FOUND |=> state == ST_CLEAR
		&& MEM_WRITE && MEM_WDATA == PAT_ZERO && MEM_ADDR == $past(AREA_FIRST))
		else $error("test does not open with clear");

	a_strobe_single: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		ERR_VALID && $past(state) == ST_IDLE |=> !ERR_VALID)
		else $error("idle report strobe too long");

endmodule // moving_inversions_error_report

// File: verif/mi_mem_model.sv
// Behavioural control memory on the checker's memory bus
`timescale 1ns/1ps
module mi_mem_model
	import mi_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              clear_counts,
	input  wire logic              slow,
	input  wire logic [15:0]       bad_rd,
	input  wire logic [WORD_W-1:0] bad_xor,
	input  wire logic [15:0]       trap_at,
	input  wire logic              trap_nxm,
	input  wire logic [ADDR_W-1:0] lo,
	input  wire logic [ADDR_W-1:0] hi,
	input  wire logic              req,
	input  wire logic              write,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [WORD_W-1:0] wdata,
	output logic                   ack,
	output logic      [WORD_W-1:0] rdata,
	output logic                   par_trap,
	output logic                   nxm_trap,
	output logic      [15:0]       n_acc,
	output logic      [15:0]       n_rd,
	output logic                   oob
);
	logic [WORD_W-1:0] mem [16];
	logic [WORD_W-1:0] last;
	logic [1:0]        waits;
	logic              done;
	logic              hit;
	logic              trap;

	// Slow mode holds off the answer for two cycles
	assign done = !slow || waits == 2'h2;
	assign hit = req && done;
	assign trap = hit && n_acc == trap_at;
	assign ack = hit && !trap;
	assign par_trap = trap && !trap_nxm;
	assign nxm_trap = trap && trap_nxm;
	// Released data lines show the inverse of the last word
	assign rdata = (ack && !write) ?
		mem[addr[3:0]] ^ ((n_rd == bad_rd) ? bad_xor : 16'h0000) : ~last;

	always @(posedge clk) begin
		if (clear_counts) begin
			n_acc <= 16'h0000;
			n_rd <= 16'h0000;
			oob <= 1'b0;
			waits <= 2'h0;
			last <= 16'h0000;
			for (int i = 0; i < 16; i++) mem[i] <= 16'h5a5a;
		end else begin
			if (req && !done) waits <= waits + 2'h1;
			if (hit) begin
				waits <= 2'h0;
				n_acc <= n_acc + 16'h0001;
			end
			if (ack && !write) begin
				n_rd <= n_rd + 16'h0001;
				last <= rdata;
			end
			if (ack && write) mem[addr[3:0]] <= wdata;
			if (req && (addr < lo || addr > hi)) oob <= 1'b1;
		end
	end
endmodule // mi_mem_model

// File: verif/moving_inversions_error_report_tb.sv
// Self-checking bench for the moving inversions checker
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin errors++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, a); end end
module moving_inversions_error_report_tb;
	import mi_pkg::*;
	logic              CLOCK, SYS_RST, START, AREA_FOUND, BUSY, TEST_DONE;
	logic              MEM_REQ, MEM_WRITE, MEM_ACK, CACHE_PARITY_TRAP;
	logic              MEM_PARITY_TRAP, NONEXISTENT_MEMORY_TRAP, ERR_VALID;
	logic              REQ_ENABLE, REQ_TEST_GO, REQ_INIT_DONE, REQ_DIAG_DONE;
	logic [ADDR_W-1:0] AREA_FIRST, AREA_LAST, MEM_ADDR;
	logic [WORD_W-1:0] MEM_WDATA, MEM_RDATA, bad_xor;
	err_record_t       ERR_RECORD;
	logic              clear_counts, slow, trap_nxm, oob, go_seen;
	logic [15:0]       bad_rd, trap_at, n_acc, n_rd;
	logic [1:0]        req_mode;
	err_record_t       q [$];
	int                errors, n_checks, cycles, n_go;

	moving_inversions_error_report #(.TIMEOUT_CYCLES(20)) dut_u (.*);
	mi_mem_model mem_u (.clk(CLOCK), .clear_counts(clear_counts),
		.slow(slow), .bad_rd(bad_rd), .bad_xor(bad_xor), .trap_at(trap_at),
		.trap_nxm(trap_nxm), .lo(AREA_FIRST), .hi(AREA_LAST),
		.req(MEM_REQ), .write(MEM_WRITE), .addr(MEM_ADDR),
		.wdata(MEM_WDATA), .ack(MEM_ACK), .rdata(MEM_RDATA),
		.par_trap(MEM_PARITY_TRAP), .nxm_trap(NONEXISTENT_MEMORY_TRAP),
		.n_acc(n_acc), .n_rd(n_rd), .oob(oob));

	initial begin
		CLOCK = 1'b0;
		forever #50 CLOCK = ~CLOCK;
	end

	// Requestor stand-in, record capture and hang guard
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			go_seen <= 1'b0;
			REQ_INIT_DONE <= 1'b0;
			REQ_DIAG_DONE <= 1'b0;
		end else begin
			go_seen <= REQ_ENABLE && (go_seen || REQ_TEST_GO);
			REQ_INIT_DONE <= REQ_ENABLE && req_mode != 2'h1;
			REQ_DIAG_DONE <= REQ_ENABLE && go_seen && req_mode == 2'h0;
		end
		if (clear_counts) n_go <= 0;
		else if (REQ_TEST_GO === 1'b1) n_go <= n_go + 1;
		if (ERR_VALID === 1'b1) q.push_back(ERR_RECORD);
		cycles++;
		if (cycles > 60000) begin
			errors++;
			finish_test();
		end
	end

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic run(input logic fnd, input logic [15:0] brd,
		input logic [15:0] bx, input logic [15:0] tat, input logic nonexistent_memory_trap,
		input logic [1:0] mode);
		int i;
		bad_rd <= brd;
		bad_xor <= bx;
		trap_at <= tat;
		trap_nxm <= nonexistent_memory_trap;
		req_mode <= mode;
		clear_counts <= 1'b1;
		@(posedge CLOCK);
		q.delete();
		clear_counts <= 1'b0;
		START <= 1'b1;
		AREA_FOUND <= fnd;
		@(posedge CLOCK);
		START <= 1'b0;
		for (i = 0; i < (fnd ? 5000 : 5) && TEST_DONE !== 1'b1; i++)
			@(negedge CLOCK);
		`CHK("done", fnd, TEST_DONE)
		repeat (4) @(posedge CLOCK);
	endtask

	task automatic mism(input logic [15:0] n, input logic [15:0] x,
		input logic [15:0] e, input logic [3:0] c, input logic [21:0] a,
		input logic d);
		run(1'b1, n, x, 16'hffff, 1'b0, 2'h0);
		`CHK("records", 1, q.size())
		if (q.size() > 0) begin
			`CHK("code", c, q[0].code)
			`CHK("address", a, q[0].failing_address)
			`CHK("expected", e, q[0].expected_pattern)
			`CHK("actual", e ^ x, q[0].actual_pattern)
			`CHK("has data", 1'b1, q[0].has_data)
			`CHK("dual", d, q[0].dual_address)
		end
	endtask

	task automatic trapchk(input logic [3:0] c, input logic [21:0] a);
		`CHK("records", 1, q.size())
		if (q.size() > 0) begin
			`CHK("code", c, q[0].code)
			`CHK("address", a, q[0].failing_address)
			`CHK("words", 32'h0, {q[0].expected_pattern,
				q[0].actual_pattern})
			`CHK("has data", 1'b0, q[0].has_data)
		end
	endtask

	task automatic t_clean;
		slow <= 1'b1;
		run(1'b1, 16'hffff, 16'h0000, 16'hffff, 1'b0, 2'h0);
		slow <= 1'b0;
		`CHK("records", 0, q.size())
		`CHK("accesses", 16'd388, n_acc)
		`CHK("reads", 16'd256, n_rd)
		`CHK("outside area", 1'b0, oob)
		`CHK("low word", 16'h0000, mem_u.mem[4])
		`CHK("high word", 16'h0000, mem_u.mem[5])
		`CHK("go pulses", 1, n_go)
		`CHK("enable off", 1'b0, REQ_ENABLE)
		$display("test clean done");
	endtask

	task automatic t_no_area;
		run(1'b0, 16'hffff, 16'h0000, 16'hffff, 1'b0, 2'h0);
		trapchk(ERR_NO_AREA, 22'h000000);
		`CHK("no access", 16'd0, n_acc)
		`CHK("idle", 1'b0, BUSY)
		$display("test no_area done");
	endtask

	task automatic t_one_adding;
		mism(16'd0, 16'h0001, 16'h0000, 4'h0, 22'h4, 1'b1);
		mism(16'd32, 16'h0100, 16'h00ff, 4'h0, 22'h4, 1'b1);
		mism(16'd60, 16'h8000, 16'h7fff, 4'h0, 22'h4, 1'b1);
		mism(16'd34, 16'h0003, 16'h00ff, 4'h0, 22'h5, 1'b0);
		mism(16'd34, 16'h0080, 16'h00ff, 4'h0, 22'h5, 1'b0);
		mism(16'd1, 16'h0002, 16'h0001, 4'h1, 22'h4, 1'b0);
		$display("test one_adding done");
	endtask

	task automatic t_zero_adding;
		mism(16'd72, 16'h2000, 16'h3fff, 4'h2, 22'h4, 1'b1);
		mism(16'd72, 16'h0400, 16'h3fff, 4'h2, 22'h4, 1'b0);
		mism(16'd68, 16'h8000, 16'h7fff, 4'h2, 22'h4, 1'b0);
		mism(16'd73, 16'h0001, 16'h1fff, 4'h3, 22'h4, 1'b0);
		$display("test zero_adding done");
	endtask

	task automatic t_descending;
		mism(16'd128, 16'h0001, 16'h0000, 4'h4, 22'h5, 1'b1);
		mism(16'd129, 16'h0002, 16'h0001, 4'h5, 22'h5, 1'b0);
		mism(16'd192, 16'h8000, 16'hffff, 4'h6, 22'h5, 1'b1);
		mism(16'd193, 16'h0001, 16'h7fff, 4'h7, 22'h5, 1'b0);
		$display("test descending done");
	endtask

	task automatic t_traps;
		run(1'b1, 16'hffff, 16'h0000, 16'd3, 1'b0, 2'h0);
		trapchk(ERR_MEM_PARITY, 22'h000004);
		`CHK("restart accesses", 16'd392, n_acc)
		run(1'b1, 16'hffff, 16'h0000, 16'd3, 1'b1, 2'h0);
		trapchk(ERR_NONEXISTENT, 22'h000004);
		fork
			run(1'b1, 16'hffff, 16'h0000, 16'hffff, 1'b0, 2'h0);
			begin
				repeat (60) @(posedge CLOCK);
				CACHE_PARITY_TRAP <= 1'b1;
				@(posedge CLOCK);
				CACHE_PARITY_TRAP <= 1'b0;
			end
		join
		trapchk(ERR_CACHE_PARITY, 22'h000000);
		$display("test traps done");
	endtask

	task automatic t_timeouts;
		run(1'b1, 16'hffff, 16'h0000, 16'hffff, 1'b0, 2'h1);
		trapchk(ERR_INIT_TIMEOUT, 22'h000000);
		`CHK("no go", 0, n_go)
		run(1'b1, 16'hffff, 16'h0000, 16'hffff, 1'b0, 2'h2);
		trapchk(ERR_DIAG_TIMEOUT, 22'h000000);
		`CHK("one go", 1, n_go)
		`CHK("enable off", 1'b0, REQ_ENABLE)
		$display("test timeouts done");
	endtask

	initial begin
		SYS_RST = 1'b1;
		START = 1'b0;
		AREA_FOUND = 1'b0;
		AREA_FIRST = 22'h000004;
		AREA_LAST = 22'h000005;
		CACHE_PARITY_TRAP = 1'b0;
		clear_counts = 1'b1;
		slow = 1'b0;
		bad_rd = 16'hffff;
		bad_xor = 16'h0000;
		trap_at = 16'hffff;
		trap_nxm = 1'b0;
		req_mode = 2'h0;
		errors = 0;
		n_checks = 0;
		cycles = 0;
		repeat (3) @(posedge CLOCK);
		SYS_RST <= 1'b0;
		t_clean();
		t_no_area();
		t_one_adding();
		t_zero_adding();
		t_descending();
		t_traps();
		t_timeouts();
		finish_test();
	end
endmodule // moving_inversions_error_report_tb
